// ---- design/lamp_pkg.sv ----
package lamp_pkg;
    localparam int word_bits = 16;
    localparam int addr_bits = 5;
    localparam int addr_msb = 14;
    localparam int channels = 4;
    localparam logic [4:0] addr_ctrl = 5'h01;
    localparam logic [4:0] addr_select = 5'h00;
    localparam logic [15:0] word_reset = 16'h0000;
    localparam logic [3:0] on_reset = 4'h0;
    localparam logic [1:0] sel_reset = 2'h0;
    localparam logic [1:0] sel_status = 2'h0;
    localparam logic [1:0] sel_config = 2'h1;
    localparam logic [1:0] sel_inputs = 2'h2;
    localparam logic [15:0] wdog_reset = 16'h0000;
    localparam int wdog_ms = 310;
    localparam int clock_mhz = 100;
    localparam int wdog_cycles = wdog_ms * 1000 * clock_mhz;
    localparam logic [3:0] flag_width = 4'h7;
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
    } spi_in_type;
    typedef struct packed {
        logic so;
        logic so_oe;
    } spi_out_type;
    typedef struct packed {
        logic [3:0] open_load;
        logic [3:0] short_bat;
        logic [3:0] over_cur;
        logic [3:0] severe;
        logic [3:0] thermal;
        logic uv;
        logic ov;
    } fault_type;
    typedef enum {st_sleep, st_normal, st_failsafe} mode_type;
endpackage

// ---- design/pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int width = 1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    logic [width-1:0] meta_reg;
    logic [width-1:0] meta_next;
    logic [width-1:0] sync_reg;
    logic [width-1:0] sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule
`default_nettype wire

// ---- design/lamp_switch_spi_mode_control.sv ----
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// R01: fault flag pin driven low while any fault exists, released otherwise.
// R02: high wake input brings device out of sleep.
// R03: reset input high wakes; low clears configuration, faults, enters sleep.
// R04: reset input rising edge restarts the watchdog timer.
// R05: with chip select high, clock and data ignored, output released.
// R06: chip select rising edge writes received word to addressed register.
// R07: chip select falling edge loads status into shift register.
// R08: serial output driver enabled whenever chip select is low.
// R09: master keeps serial clock low at every chip select transition.
// R10: each data bit sampled on serial clock falling edge.
// R11: serial output changes on each serial clock rising edge.
// R12: master sends exactly sixteen bits per frame, msb first.
// R13: five-bit address field of word selects target register.
// R14: loss of logic supply enters fail-safe mode.
// R15: open fail-safe select enables watchdog; timeout: outputs follow inputs.
// R16: grounded fail-safe select disables watchdog; supply loss needs enable.
// R17: normal mode outputs follow serial on bits, optionally pwm; code also ors in direct inputs not set in dir_dis_reg while pwm is off.
// R18: fail-safe outputs follow direct inputs; config reverts to default; code keeps vdd_fail_en_reg in fail-safe.
// R19: per-output fault flags reported through serial status word.
// R20: watchdog timeout or supply failure enters fail-safe mode.
// R21: output word reports status, configuration or inputs as selected.
// R22: wake condition is reset or wake or any direct input.
// R23: in sleep every configurable feature acts as if zero.
// R24: captured status stays frozen in shift register for whole frame.
module lamp_switch_spi_mode_control #(
    parameter int wdog_limit = lamp_pkg::wdog_cycles
) (
    input wire logic clock,
    input wire logic rst,
    input wire lamp_pkg::spi_in_type spi_in,
    output lamp_pkg::spi_out_type spi_out,
    input wire logic reset_in,
    input wire logic wake_in,
    input wire logic failsafe_select_in,
    input wire logic vdd_fail_in,
    input wire logic [3:0] direct_in,
    input wire lamp_pkg::fault_type fault_in,
    input wire logic pwm_gate,
    output logic [3:0] high_side_output,
    output logic fault_flag_n,
    output logic fault_flag_oe,
    output logic awake,
    output logic failsafe
);
    // all pins except fault_in cross into the clock domain first
    localparam int sync_w = 12;
    logic [sync_w-1:0] sync_raw;
    logic [sync_w-1:0] sync_pins;
    logic cs_n_s;
    logic sclk_s;
    logic si_s;
    logic rst_s;
    logic wake_s;
    logic fsi_s;
    logic vdd_fail_s;
    logic pwm_s;
    logic [3:0] din_s;

    // select crosses inverted so it leaves reset at its idle high level
    assign sync_raw = {!spi_in.cs_n, spi_in.sclk, spi_in.si, reset_in,
        wake_in, failsafe_select_in, vdd_fail_in, pwm_gate, direct_in};

    pin_sync #(.width(sync_w)) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in(sync_raw),
        .sync_out(sync_pins)
    );

    assign {cs_n_s, sclk_s, si_s, rst_s, wake_s, fsi_s, vdd_fail_s, pwm_s,
        din_s} = sync_pins ^ 12'h800;

    // edge history
    logic cs_n_d_reg;
    logic sclk_d_reg;
    logic rst_d_reg;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic sclk_rise;
    logic rst_rise;
    logic wake_cond;

    assign cs_fall = cs_n_d_reg && !cs_n_s;
    assign cs_rise = !cs_n_d_reg && cs_n_s;
    assign sclk_fall = sclk_d_reg && !sclk_s && !cs_n_s; // R05 R10
    assign sclk_rise = !sclk_d_reg && sclk_s && !cs_n_s; // R05 R11
    assign rst_rise = !rst_d_reg && rst_s;
    assign wake_cond = rst_s || wake_s || (|din_s); // R02 R03 R22

    // serial engine
    logic [15:0] rx_reg;
    logic [15:0] rx_next;
    logic [15:0] tx_reg;
    logic [15:0] tx_next;
    logic [4:0] bits_reg;
    logic [4:0] bits_next;
    logic so_reg;
    logic so_next;
    logic so_oe_reg;
    logic so_oe_next;
    logic first_reg;
    logic first_next;
    logic [15:0] status_word;

    // configuration
    logic [3:0] on_reg;
    logic [3:0] on_next;
    logic [3:0] dir_dis_reg;
    logic [3:0] dir_dis_next;
    logic pwm_en_reg;
    logic pwm_en_next;
    logic vdd_fail_en_reg;
    logic vdd_fail_en_next;
    logic [1:0] sel_reg;
    logic [1:0] sel_next;

    // mode and watchdog
    lamp_pkg::mode_type mode_reg;
    lamp_pkg::mode_type mode_next;
    logic [31:0] wdog_reg;
    logic [31:0] wdog_next;
    logic wdog_to_reg;
    logic wdog_to_next;
    logic [3:0] hs_reg;
    logic [3:0] hs_next;
    logic flag_n_reg;
    logic flag_n_next;
    logic flag_oe_reg;
    logic flag_oe_next;
    logic awake_reg;
    logic awake_next;
    logic fs_reg;
    logic fs_next;
    logic any_fault;
    logic fail;

    assign any_fault = (|fault_in.over_cur) || (|fault_in.thermal) ||
        (|fault_in.severe) || (|fault_in.short_bat) ||
        (|fault_in.open_load) || fault_in.uv || fault_in.ov;
    // watchdog only counts when the select pin floats high
    assign fail = (vdd_fail_s && vdd_fail_en_reg) // R14 R16
        || (wdog_to_reg && fsi_s); // R15 R20

    always_comb begin
        case (sel_reg) // R19 R21
            lamp_pkg::sel_config:
                status_word = {3'h1, pwm_en_reg, vdd_fail_en_reg,
                    3'h0, dir_dis_reg, on_reg};
            lamp_pkg::sel_inputs:
                status_word = {3'h2, 5'h00, rst_s, wake_s, fsi_s, vdd_fail_s,
                    din_s};
            default:
                status_word = {fault_in.over_cur | fault_in.severe,
                    fault_in.thermal, fault_in.open_load | fault_in.short_bat,
                    fault_in.uv, fault_in.ov,
                    mode_reg == lamp_pkg::st_failsafe, any_fault};
        endcase
    end

    always_comb begin
        rx_next = rx_reg;
        tx_next = tx_reg;
        bits_next = bits_reg;
        so_next = so_reg;
        so_oe_next = !cs_n_s; // R08 R05
        first_next = first_reg;
        if (cs_fall) begin
            tx_next = status_word; // R07 R24
            bits_next = 5'h00;
            so_next = status_word[15];
            first_next = 1'b1;
        end else if (sclk_rise) begin
            // first rising edge presents msb, later ones shift
            if (first_reg) begin
                first_next = 1'b0;
            end else begin
                tx_next = {tx_reg[14:0], 1'b0};
            end
            so_next = first_reg ? tx_reg[15] : tx_reg[14]; // R11
        end
        if (sclk_fall) begin
            rx_next = {rx_reg[14:0], si_s}; // R10 R12
            if (bits_reg != 5'h1f) begin
                bits_next = bits_reg + 5'h01;
            end
        end
        if (cs_n_s) begin
            so_next = 1'b0;
        end
    end

    always_comb begin
        on_next = on_reg;
        dir_dis_next = dir_dis_reg;
        pwm_en_next = pwm_en_reg;
        vdd_fail_en_next = vdd_fail_en_reg;
        sel_next = sel_reg;
        // only complete 16-bit words are accepted
        if (cs_rise && bits_reg == 5'h10) begin // R06 R12
            case (rx_reg[lamp_pkg::addr_msb -: lamp_pkg::addr_bits]) // R13
                lamp_pkg::addr_ctrl: begin
                    on_next = rx_reg[3:0];
                    dir_dis_next = rx_reg[7:4];
                    pwm_en_next = rx_reg[8];
                    vdd_fail_en_next = rx_reg[9];
                end
                lamp_pkg::addr_select: begin
                    sel_next = rx_reg[1:0];
                end
                default: sel_next = sel_reg;
            endcase
        end
        if (mode_reg != lamp_pkg::st_normal) begin
            on_next = lamp_pkg::on_reset; // R18 R23
            dir_dis_next = lamp_pkg::on_reset;
            pwm_en_next = 1'b0;
            sel_next = lamp_pkg::sel_reset;
            if (mode_reg == lamp_pkg::st_sleep) begin
                vdd_fail_en_next = 1'b0;
            end
        end
        if (!rst_s) begin
            on_next = lamp_pkg::on_reset; // R03
            dir_dis_next = lamp_pkg::on_reset;
            pwm_en_next = 1'b0;
            vdd_fail_en_next = 1'b0;
            sel_next = lamp_pkg::sel_reset;
        end
    end

    always_comb begin
        mode_next = mode_reg;
        wdog_next = wdog_reg;
        wdog_to_next = wdog_to_reg;
        hs_next = 4'h0;
        flag_n_next = !any_fault; // R01
        flag_oe_next = any_fault; // R01
        if (rst_rise || cs_rise) begin
            wdog_next = 32'h0; // R04
            wdog_to_next = 1'b0;
        end else if (fsi_s && rst_s && wdog_reg < 32'(wdog_limit)) begin
            wdog_next = wdog_reg + 32'h1;
        end else if (fsi_s && rst_s) begin
            wdog_to_next = 1'b1;
        end
        if (!rst_s) begin
            wdog_to_next = 1'b0;
        end
        case (mode_reg)
            lamp_pkg::st_sleep: begin
                if (wake_cond) begin // R02
                    mode_next = lamp_pkg::st_normal;
                end
            end
            lamp_pkg::st_normal: begin
                hs_next = ((din_s & ~dir_dis_reg) | on_reg) & // R17
                    {4{!pwm_en_reg}} | (on_reg & {4{pwm_en_reg && pwm_s}});
                if (fail) begin
                    mode_next = lamp_pkg::st_failsafe; // R14 R20
                end
            end
            lamp_pkg::st_failsafe: begin
                hs_next = din_s; // R18 R15
                if (!fail) begin
                    mode_next = lamp_pkg::st_normal;
                end
            end
            default: mode_next = lamp_pkg::st_sleep;
        endcase
        if (!wake_cond) begin
            mode_next = lamp_pkg::st_sleep; // R22 R03
        end
        awake_next = (mode_next != lamp_pkg::st_sleep);
        fs_next = (mode_next == lamp_pkg::st_failsafe);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cs_n_d_reg <= 1'b1;
            sclk_d_reg <= 1'b0;
            rst_d_reg <= 1'b0;
            rx_reg <= lamp_pkg::word_reset;
            tx_reg <= lamp_pkg::word_reset;
            bits_reg <= 5'h00;
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
            first_reg <= 1'b0;
            on_reg <= lamp_pkg::on_reset;
            dir_dis_reg <= lamp_pkg::on_reset;
            pwm_en_reg <= 1'b0;
            vdd_fail_en_reg <= 1'b0;
            sel_reg <= lamp_pkg::sel_reset;
            mode_reg <= lamp_pkg::st_sleep;
            wdog_reg <= 32'h0;
            wdog_to_reg <= 1'b0;
            hs_reg <= 4'h0;
            flag_n_reg <= 1'b1;
            flag_oe_reg <= 1'b0;
            awake_reg <= 1'b0;
            fs_reg <= 1'b0;
        end else begin
            cs_n_d_reg <= cs_n_s;
            sclk_d_reg <= sclk_s;
            rst_d_reg <= rst_s;
            rx_reg <= rx_next;
            tx_reg <= tx_next;
            bits_reg <= bits_next;
            so_reg <= so_next;
            so_oe_reg <= so_oe_next;
            first_reg <= first_next;
            on_reg <= on_next;
            dir_dis_reg <= dir_dis_next;
            pwm_en_reg <= pwm_en_next;
            vdd_fail_en_reg <= vdd_fail_en_next;
            sel_reg <= sel_next;
            mode_reg <= mode_next;
            wdog_reg <= wdog_next;
            wdog_to_reg <= wdog_to_next;
            hs_reg <= hs_next;
            flag_n_reg <= flag_n_next;
            flag_oe_reg <= flag_oe_next;
            awake_reg <= awake_next;
            fs_reg <= fs_next;
        end
    end

    assign spi_out.so = so_reg;
    assign spi_out.so_oe = so_oe_reg;
    assign high_side_output = hs_reg;
    assign fault_flag_n = flag_n_reg;
    assign fault_flag_oe = flag_oe_reg;
    assign awake = awake_reg;
    assign failsafe = fs_reg;
endmodule
`default_nettype wire

// ---- tb/lamp_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module lamp_asserts (
    input wire logic clock,
    input wire logic rst,
    input wire lamp_pkg::spi_in_type spi_in,
    input wire lamp_pkg::spi_out_type spi_out,
    input wire logic reset_in,
    input wire logic wake_in,
    input wire logic failsafe_select_in,
    input wire logic vdd_fail_in,
    input wire logic [3:0] direct_in,
    input wire lamp_pkg::fault_type fault_in,
    input wire logic pwm_gate,
    input wire logic [3:0] high_side_output,
    input wire logic fault_flag_n,
    input wire logic fault_flag_oe,
    input wire logic awake,
    input wire logic failsafe
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    // five cycles cover the two sync stages plus the output register
    sequence deselected;
        spi_in.cs_n [*5];
    endsequence
    sequence selected;
        !spi_in.cs_n [*5];
    endsequence
    wire logic quiet = !(reset_in || wake_in || (|direct_in));
    a_so_released: assert property (
        deselected |-> !spi_out.so_oe && !spi_out.so)
        else $error("so driven while deselected");
    a_so_driven: assert property (selected |-> spi_out.so_oe)
        else $error("so not driven while selected");
    a_so_holds: assert property (
        (!spi_in.cs_n && !spi_in.sclk) [*8] |-> $stable(spi_out.so))
        else $error("so moved without a clock rise");
    a_flag_on: assert property (
        (|fault_in) [*3] |-> fault_flag_oe && !fault_flag_n)
        else $error("fault pin not pulled low");
    a_flag_off: assert property (
        !(|fault_in) [*3] |-> !fault_flag_oe && fault_flag_n)
        else $error("fault pin not released");
    a_sleep_dark: assert property (
        !awake [*2] |-> high_side_output == 4'h0)
        else $error("output on while asleep");
    a_quiet_sleeps: assert property (quiet [*5] |-> !awake)
        else $error("awake with no wake source");
    a_wake_rises: assert property (wake_in [*5] |-> awake)
        else $error("wake input did not wake");
    a_failsafe_inputs: assert property (
        (failsafe && $stable(direct_in)) [*5]
        |-> high_side_output == direct_in)
        else $error("fail-safe output not following inputs");
    a_no_spurious_fail: assert property (
        (!failsafe_select_in && !vdd_fail_in) [*5] |-> !failsafe)
        else $error("fail-safe with no cause");
endmodule
`default_nettype wire

// ---- tb/spi_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    input wire logic clock,
    input wire logic so,
    output var lamp_pkg::spi_in_type pins
);
    initial pins = '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
    task automatic half();
        repeat (8) @(negedge clock);
    endtask
    // bits below 16 only for frames meant to be refused
    task automatic xfer(input logic [15:0] word, input int bits,
                        output logic [15:0] rd);
        rd = 16'h0000;
        pins.cs_n = 1'b0;
        half();
        for (int i = bits - 1; i >= 0; i--) begin
            pins.sclk = 1'b1;
            pins.si = word[i];
            half();
            rd[i] = so;
            pins.sclk = 1'b0;
            half();
        end
        pins.cs_n = 1'b1;
        pins.si = 1'b0;
        half();
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int wdog = 200;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic reset_in = 1'b0;
    logic wake_in = 1'b0;
    logic failsafe_select_in = 1'b0;
    logic vdd_fail_in = 1'b0;
    logic pwm_gate = 1'b0;
    logic [3:0] direct_in = 4'h0;
    lamp_pkg::fault_type fault_in = '0;
    lamp_pkg::spi_in_type spi_in;
    lamp_pkg::spi_out_type spi_out;
    logic [3:0] high_side_output;
    logic fault_flag_n;
    logic fault_flag_oe;
    logic awake;
    logic failsafe;
    logic [15:0] rd;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    // open drain with pull-up: released pin reads high
    wire logic fault_pin = fault_flag_oe ? fault_flag_n : 1'b1;
    always #5 clock = ~clock;
    lamp_switch_spi_mode_control #(.wdog_limit(wdog))
        lamp_switch_spi_mode_control_inst (.clock(clock), .rst(rst),
        .spi_in(spi_in), .spi_out(spi_out), .reset_in(reset_in),
        .wake_in(wake_in), .failsafe_select_in(failsafe_select_in),
        .vdd_fail_in(vdd_fail_in), .direct_in(direct_in),
        .fault_in(fault_in), .pwm_gate(pwm_gate),
        .high_side_output(high_side_output), .fault_flag_n(fault_flag_n),
        .fault_flag_oe(fault_flag_oe), .awake(awake), .failsafe(failsafe));
    spi_host_model spi_host_model_inst (.clock(clock), .so(spi_out.so),
        .pins(spi_in));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic summarize();
        $display("mismatches %0d compared %0d", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic s_wake();
        chk(16'({awake, spi_out.so_oe, fault_pin, high_side_output}),
            16'h0010);
        wake_in = 1'b1;
        tick(6);
        chk(16'(awake), 16'h0001);
        wake_in = 1'b0;
        tick(6);
        chk(16'(awake), 16'h0000);
        reset_in = 1'b1;
        tick(6);
        chk(16'(awake), 16'h0001);
    endtask
    task automatic s_status();
        fault_in.thermal = 4'h5;
        fault_in.uv = 1'b1;
        tick(3);
        chk(16'(fault_pin), 16'h0000);
        fork
            spi_host_model_inst.xfer(16'h0000, 16, rd);
            begin
                tick(40);
                fault_in.thermal = 4'ha;
            end
        join
        chk(rd, 16'h0509);
        fault_in = '0;
        tick(3);
        chk(16'(fault_pin), 16'h0001);
    endtask
    task automatic s_write();
        spi_host_model_inst.xfer(16'h0405, 16, rd);
        tick(6);
        chk(16'(high_side_output), 16'h0005);
        spi_host_model_inst.xfer(16'h040a, 15, rd);
        tick(6);
        chk(16'(high_side_output), 16'h0005);
        spi_host_model_inst.xfer(16'h080a, 16, rd);
        tick(6);
        chk(16'(high_side_output), 16'h0005);
    endtask
    task automatic s_select();
        spi_host_model_inst.xfer(16'h0001, 16, rd);
        spi_host_model_inst.xfer(16'h0002, 16, rd);
        chk(rd, 16'h2005);
        spi_host_model_inst.xfer(16'h0000, 16, rd);
        chk(rd, 16'h4080);
        spi_host_model_inst.xfer(16'h0505, 16, rd);
        pwm_gate = 1'b1;
        tick(6);
        chk(16'(high_side_output), 16'h0005);
        pwm_gate = 1'b0;
        tick(6);
        chk(16'(high_side_output), 16'h0000);
        spi_host_model_inst.xfer(16'h04c0, 16, rd);
        direct_in = 4'hf;
        tick(6);
        chk(16'(high_side_output), 16'h0003);
        direct_in = 4'h0;
    endtask
    task automatic s_failsafe();
        failsafe_select_in = 1'b1;
        direct_in = 4'h3;
        tick(300);
        chk(16'({failsafe, high_side_output}), 16'h0013);
        failsafe_select_in = 1'b0;
        direct_in = 4'h0;
        tick(8);
        chk(16'({failsafe, high_side_output}), 16'h0000);
    endtask
    task automatic s_supply();
        vdd_fail_in = 1'b1;
        tick(8);
        chk(16'(failsafe), 16'h0000);
        vdd_fail_in = 1'b0;
        spi_host_model_inst.xfer(16'h0600, 16, rd);
        vdd_fail_in = 1'b1;
        tick(8);
        chk(16'(failsafe), 16'h0001);
        spi_host_model_inst.xfer(16'h0000, 16, rd);
        chk(rd, 16'h0002);
        vdd_fail_in = 1'b0;
        tick(8);
    endtask
    task automatic s_sleep();
        reset_in = 1'b0;
        tick(8);
        chk(16'({awake, high_side_output}), 16'h0000);
    endtask
    initial begin
        tick(20);
        rst = 1'b0;
        tick(4);
        s_wake();
        s_status();
        s_write();
        s_select();
        s_failsafe();
        s_supply();
        s_sleep();
        summarize();
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
endmodule
bind lamp_switch_spi_mode_control lamp_asserts lamp_asserts_inst (
    .clock(clock), .rst(rst), .spi_in(spi_in), .spi_out(spi_out),
    .reset_in(reset_in), .wake_in(wake_in),
    .failsafe_select_in(failsafe_select_in), .vdd_fail_in(vdd_fail_in),
    .direct_in(direct_in), .fault_in(fault_in), .pwm_gate(pwm_gate),
    .high_side_output(high_side_output), .fault_flag_n(fault_flag_n),
    .fault_flag_oe(fault_flag_oe), .awake(awake), .failsafe(failsafe));
`default_nettype wire
